// >>> src/glue_pkg.sv
package glue_pkg;
    // supply latch state after reset: regulator off
    localparam logic SUPPLY_LATCH_RST = 1'b0;
    // tone enable state after reset
    localparam logic TONE_RST = 1'b0;
    localparam logic TONE_INHIBIT_RST = 1'b0;
    // key protection key width in bits
    localparam int KEY_WIDTH = 64;
    // card clock divide ratio (processor clock / 2)
    localparam int CARD_CLK_DIV = 2;
    localparam logic CARD_CLK_RST = 1'b0;
    // synchroniser depth for pin inputs
    localparam int SYNC_STAGES = 2;
    // number of asynchronous pin inputs
    localparam int PIN_COUNT = 11;
    // bit positions in the synchronised pin vector
    localparam int P_POWER_KEY = 0;
    localparam int P_LOW_BATT = 1;
    localparam int P_CARD_A = 2;
    localparam int P_CARD_B = 3;
    localparam int P_NUM_PAD = 4;
    localparam int P_FUNC_PAD = 5;
    localparam int P_TAMPER = 6;
    localparam int P_FIVE_V = 7;
    localparam int P_BACKUP_LOST = 8;
    localparam int P_CARD_TONE = 9;
    localparam int P_NUM_KEYS = 10;
    // synchroniser reset value: all inactive (active-low inputs high)
    localparam logic [PIN_COUNT-1:0] PIN_IDLE = 11'h03E;
endpackage

// >>> src/pin_sync.sv
`timescale 1ns/10ps
module pin_sync
    import glue_pkg::*;
#(
    parameter int WIDTH = PIN_COUNT,
    parameter logic [WIDTH-1:0] IDLE = PIN_IDLE
) (
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } sync_s;

    sync_s state;
    sync_s next_state;

    always_comb begin
        next_state = state;
        next_state.stage1 = async_i;
        next_state.stage2 = state.stage1;
        if (!reset_n_i) begin
            next_state.stage1 = IDLE;
            next_state.stage2 = IDLE;
        end
    end

    always_ff @(posedge clock_i) begin
        state <= next_state;
    end

    assign sync_o = state.stage2;
endmodule

// >>> src/power_latch_irq_glue.sv
// Overview of operation
// [RULE1] power off: power key press sets supply latch, no processor needed
// [RULE2] power on: power key press only raises the function keypad interrupt
// [RULE3] processor clears supply latch via control output; regulator turns off
// [RULE4] tone switched by processor or card; processor inhibit blocks card tone
// [RULE5] card clock derived from processor output clock at lower rate
// [RULE6] processor holds reset low until oscillator stable, may reassert later
// [RULE7] low battery detector routed to interrupt level two
// [RULE8] card interrupts a and b routed to levels three and four
// [RULE9] numeric keypad to level five, function keypad to level six
// [RULE10] tamper and five-volt detect combined on level seven; tamper also alone
// [RULE11] processor reads tamper input first on level seven request
// [RULE12] key protection key clears on tamper or backup supply loss
// [RULE13] keypad has write and read selects; tone uses keypad write select
// [RULE14] any numeric key press asserts numeric keypad interrupt
// [RULE15] card clock is processor output clock divided by exactly two
// [RULE16] interrupt requests active low, held while source condition persists
`timescale 1ns/10ps
module power_latch_irq_glue
    import glue_pkg::*;
#(
    parameter int NUM_KEYS = 16,
    parameter int KEY_BITS = KEY_WIDTH
) (
    input wire logic CLOCK_I,
    input wire logic RESET_N_I,
    input wire logic POWER_KEY_N_I,
    input wire logic SUPPLY_OFF_N_I,
    input wire logic LOW_BATT_N_I,
    input wire logic CARD_IRQ_A_N_I,
    input wire logic CARD_IRQ_B_N_I,
    input wire logic [NUM_KEYS-1:0] NUM_KEYS_N_I,
    input wire logic FUNC_PAD_IRQ_N_I,
    input wire logic TAMPER_N_I,
    input wire logic FIVE_V_DETECT_N_I,
    input wire logic BACKUP_LOST_N_I,
    input wire logic CARD_TONE_I,
    input wire logic KEY_WRITE_SEL_N_I,
    input wire logic KEY_READ_SEL_N_I,
    input wire logic [2:0] PROC_DATA_I,
    input wire logic [KEY_BITS-1:0] KEY_LOAD_I,
    input wire logic KEY_LOAD_EN_I,
    output logic SUPPLY_EN_O,
    output logic TONE_EN_O,
    output logic CARD_CLK_O,
    output logic [2:0] KEYPAD_READ_DATA_O,
    output logic KEYPAD_READ_OE_O,
    output logic [7:1] IRQ_N_O,
    output logic TAMPER_SENSE_IN_O,
    output logic [KEY_BITS-1:0] KEY_PROTECT_KEY_O
);
    typedef struct packed {
        logic supply_latch;
        logic key_seen;
        logic on_press;
        logic proc_tone;
        logic tone_inhibit;
        logic write_sel_d;
        logic card_clk;
        logic [6:0] irq_n;
        logic tamper_sense_in;
        logic tone_en;
        logic [KEY_BITS-1:0] key_protect_key;
    } glue_s;

    glue_s state;
    glue_s next_state;
    logic [PIN_COUNT-1:0] pins;
    logic any_num_key;
    logic [2:0] read_data;

    // any numeric key pressed (keys active low)
    assign any_num_key = ~&NUM_KEYS_N_I; // [RULE14]

    pin_sync #(
        .WIDTH(PIN_COUNT),
        .IDLE(PIN_IDLE)
    ) u_sync (
        .clock_i(CLOCK_I),
        .reset_n_i(RESET_N_I),
        .async_i({any_num_key, CARD_TONE_I, ~BACKUP_LOST_N_I, ~FIVE_V_DETECT_N_I,
            ~TAMPER_N_I, FUNC_PAD_IRQ_N_I, NUM_KEYS_N_I[0] & ~any_num_key,
            CARD_IRQ_B_N_I, CARD_IRQ_A_N_I, LOW_BATT_N_I, ~POWER_KEY_N_I}),
        .sync_o(pins)
    );

    always_comb begin
        next_state = state;
        // supply latch
        if (pins[P_POWER_KEY] && !state.key_seen && !state.supply_latch) begin
            next_state.supply_latch = 1'b1; // [RULE1]
        end else if (!SUPPLY_OFF_N_I) begin
            next_state.supply_latch = 1'b0; // [RULE3]
        end
        next_state.key_seen = pins[P_POWER_KEY];
        // only a press begun with supply on asks for shutdown
        if (!pins[P_POWER_KEY]) begin
            next_state.on_press = 1'b0;
        end else if (!state.key_seen && state.supply_latch) begin
            next_state.on_press = 1'b1; // [RULE2]
        end
        // tone control via keypad write select strobe
        next_state.write_sel_d = KEY_WRITE_SEL_N_I;
        if (!KEY_WRITE_SEL_N_I && state.write_sel_d) begin
            next_state.proc_tone = PROC_DATA_I[0]; // [RULE13]
            next_state.tone_inhibit = PROC_DATA_I[1];
        end
        next_state.tone_en = state.proc_tone |
            (pins[P_CARD_TONE] & ~state.tone_inhibit); // [RULE4]
        // card clock toggles every rising edge: divide by two
        next_state.card_clk = ~state.card_clk; // [RULE5] [RULE15]
        // interrupt routing, levels held while source active
        next_state.irq_n[0] = 1'b1;
        next_state.irq_n[1] = pins[P_LOW_BATT]; // [RULE7] [RULE16]
        next_state.irq_n[2] = pins[P_CARD_A]; // [RULE8]
        next_state.irq_n[3] = pins[P_CARD_B]; // [RULE8]
        next_state.irq_n[4] = ~pins[P_NUM_KEYS]; // [RULE9] [RULE14]
        next_state.irq_n[5] = pins[P_FUNC_PAD] & ~state.on_press; // [RULE2] [RULE9]
        next_state.irq_n[6] = ~(pins[P_TAMPER] | pins[P_FIVE_V]); // [RULE10]
        next_state.tamper_sense_in = ~pins[P_TAMPER]; // [RULE10]
        // key protection key
        if (pins[P_TAMPER] || pins[P_BACKUP_LOST]) begin
            next_state.key_protect_key = '0; // [RULE12]
        end else if (KEY_LOAD_EN_I) begin
            next_state.key_protect_key = KEY_LOAD_I;
        end
        if (!RESET_N_I) begin
            next_state.supply_latch = SUPPLY_LATCH_RST;
            next_state.key_seen = 1'b0;
            next_state.on_press = 1'b0;
            next_state.proc_tone = TONE_RST;
            next_state.tone_inhibit = TONE_INHIBIT_RST;
            next_state.write_sel_d = 1'b1;
            next_state.card_clk = CARD_CLK_RST;
            next_state.irq_n = 7'h7F;
            next_state.tamper_sense_in = 1'b1;
            next_state.tone_en = 1'b0;
            next_state.key_protect_key = state.key_protect_key;
        end
    end

    always_ff @(posedge CLOCK_I) begin
        state <= next_state;
    end

    // keypad read select returns power key, function keypad request and supply latch state
    always_comb begin
        read_data = 3'h0;
        read_data[0] = pins[P_POWER_KEY];
        read_data[1] = ~pins[P_FUNC_PAD];
        read_data[2] = state.supply_latch;
    end

    assign KEYPAD_READ_OE_O = ~KEY_READ_SEL_N_I; // [RULE13]
    assign KEYPAD_READ_DATA_O = read_data;
    assign SUPPLY_EN_O = state.supply_latch;
    assign TONE_EN_O = state.tone_en;
    assign CARD_CLK_O = state.card_clk;
    assign IRQ_N_O = state.irq_n;
    assign TAMPER_SENSE_IN_O = state.tamper_sense_in;
    assign KEY_PROTECT_KEY_O = state.key_protect_key;
endmodule

// >>> test/glue_props.sv
`timescale 1ns/10ps
module glue_props #(
    parameter int KEY_BITS = 64
) (
    input wire logic CLOCK_I,
    input wire logic RESET_N_I,
    input wire logic LOW_BATT_N_I,
    input wire logic CARD_IRQ_A_N_I,
    input wire logic TAMPER_N_I,
    input wire logic FIVE_V_DETECT_N_I,
    input wire logic BACKUP_LOST_N_I,
    input wire logic SUPPLY_OFF_N_I,
    input wire logic POWER_KEY_N_I,
    input wire logic SUPPLY_EN_O,
    input wire logic CARD_CLK_O,
    input wire logic [7:1] IRQ_N_O,
    input wire logic TAMPER_SENSE_IN_O,
    input wire logic [KEY_BITS-1:0] KEY_PROTECT_KEY_O
);
    logic [2:0] up;
    always_ff @(posedge CLOCK_I) begin
        if (!RESET_N_I) begin
            up <= 3'h0;
        end else if (up != 3'h7) begin
            up <= up + 3'h1;
        end
    end
    default clocking @(posedge CLOCK_I); endclocking
    default disable iff (!RESET_N_I);
    a_low_batt_route: assert property (
        up > 3'h3 |-> IRQ_N_O[2] == $past(LOW_BATT_N_I, 3)) else $error("level two wrong");
    a_card_a_route: assert property (
        up > 3'h3 |-> IRQ_N_O[3] == $past(CARD_IRQ_A_N_I, 3)) else $error("level three wrong");
    a_tamper_alone: assert property (
        up > 3'h3 |-> TAMPER_SENSE_IN_O == $past(TAMPER_N_I, 3)) else $error("tamper sense wrong");
    a_level_seven: assert property (
        up > 3'h3 |-> IRQ_N_O[7] == ($past(TAMPER_N_I, 3) && $past(FIVE_V_DETECT_N_I, 3)))
        else $error("level seven wrong");
    a_card_clk_div: assert property (
        up > 3'h1 |-> CARD_CLK_O != $past(CARD_CLK_O)) else $error("card clock stuck");
    a_supply_clear: assert property (
        !SUPPLY_OFF_N_I && $past(POWER_KEY_N_I, 1) && $past(POWER_KEY_N_I, 2)
        && $past(POWER_KEY_N_I, 3) |=> !SUPPLY_EN_O) else $error("latch not cleared");
    a_supply_hold: assert property (
        SUPPLY_EN_O && SUPPLY_OFF_N_I |=> SUPPLY_EN_O) else $error("latch dropped");
    a_key_clear: assert property (
        up > 3'h3 && !($past(TAMPER_N_I, 3) && $past(BACKUP_LOST_N_I, 3))
        |-> KEY_PROTECT_KEY_O == '0) else $error("key kept");
endmodule
bind power_latch_irq_glue glue_props #(.KEY_BITS(KEY_BITS)) glue_props_i (
    .CLOCK_I(CLOCK_I), .RESET_N_I(RESET_N_I), .LOW_BATT_N_I(LOW_BATT_N_I),
    .CARD_IRQ_A_N_I(CARD_IRQ_A_N_I), .TAMPER_N_I(TAMPER_N_I),
    .FIVE_V_DETECT_N_I(FIVE_V_DETECT_N_I), .BACKUP_LOST_N_I(BACKUP_LOST_N_I),
    .SUPPLY_OFF_N_I(SUPPLY_OFF_N_I), .POWER_KEY_N_I(POWER_KEY_N_I),
    .SUPPLY_EN_O(SUPPLY_EN_O), .CARD_CLK_O(CARD_CLK_O), .IRQ_N_O(IRQ_N_O),
    .TAMPER_SENSE_IN_O(TAMPER_SENSE_IN_O), .KEY_PROTECT_KEY_O(KEY_PROTECT_KEY_O));

// >>> test/host_model.sv
`timescale 1ns/10ps
module host_model #(
    parameter int CLEANUP = 5
) (
    input wire logic clock_i,
    input wire logic [7:1] irq_n_i,
    input wire logic tamper_i,
    input wire logic arm_i,
    output logic reset_n_o,
    output logic supply_off_n_o,
    output logic cause_o
);
    int busy = 0;
    initial begin
        reset_n_o = 1'b0;
        supply_off_n_o = 1'b1;
        cause_o = 1'b0;
        repeat (3) @(negedge clock_i);
        reset_n_o = 1'b1;
    end
    // cleanup waits for arm, then one clearing pulse
    always @(negedge clock_i) begin
        supply_off_n_o <= !(busy == 1 && arm_i);
        cause_o <= !irq_n_i[7] && !tamper_i;
        if (!irq_n_i[6] && busy == 0) begin
            busy <= CLEANUP;
        end else if (busy > 1 || (busy == 1 && arm_i)) begin
            busy <= busy - 1;
        end
    end
endmodule

// >>> test/tb.sv
`timescale 1ns/10ps
module tb;
    import glue_pkg::*;
    localparam logic [63:0] KEYV = 64'hA5A5_0F0F_3C3C_9696;
    logic CLOCK_I = 1'b0, RESET_N_I, SUPPLY_OFF_N_I, POWER_KEY_N_I = 1'b1, CARD_TONE_I = 1'b0;
    logic BACKUP_LOST_N_I = 1'b1, KEY_WRITE_SEL_N_I = 1'b1, KEY_READ_SEL_N_I = 1'b1;
    logic [2:0] PROC_DATA_I = 3'h0;
    logic [63:0] KEY_LOAD_I = 64'h0;
    logic KEY_LOAD_EN_I = 1'b0, arm = 1'b0, cause, num_n;
    logic [6:0] src = 7'h7F;
    wire logic LOW_BATT_N_I, CARD_IRQ_A_N_I, CARD_IRQ_B_N_I, FUNC_PAD_IRQ_N_I;
    wire logic TAMPER_N_I, FIVE_V_DETECT_N_I, SUPPLY_EN_O, TONE_EN_O, CARD_CLK_O;
    wire logic KEYPAD_READ_OE_O, TAMPER_SENSE_IN_O;
    wire logic [2:0] KEYPAD_READ_DATA_O;
    wire logic [7:1] IRQ_N_O;
    wire logic [63:0] KEY_PROTECT_KEY_O;
    wire logic [15:0] NUM_KEYS_N_I = {num_n, 15'h7FFF};
    int n_errors = 0;
    int checks_done = 0;
    assign {TAMPER_N_I, FIVE_V_DETECT_N_I, FUNC_PAD_IRQ_N_I, num_n} = src[6:3];
    assign {CARD_IRQ_B_N_I, CARD_IRQ_A_N_I, LOW_BATT_N_I} = src[2:0];
    always #50 CLOCK_I = !CLOCK_I;
    power_latch_irq_glue power_latch_irq_glue_i (
        .CLOCK_I(CLOCK_I), .RESET_N_I(RESET_N_I), .POWER_KEY_N_I(POWER_KEY_N_I),
        .SUPPLY_OFF_N_I(SUPPLY_OFF_N_I), .LOW_BATT_N_I(LOW_BATT_N_I),
        .CARD_IRQ_A_N_I(CARD_IRQ_A_N_I), .CARD_IRQ_B_N_I(CARD_IRQ_B_N_I),
        .NUM_KEYS_N_I(NUM_KEYS_N_I), .FUNC_PAD_IRQ_N_I(FUNC_PAD_IRQ_N_I),
        .TAMPER_N_I(TAMPER_N_I), .FIVE_V_DETECT_N_I(FIVE_V_DETECT_N_I),
        .BACKUP_LOST_N_I(BACKUP_LOST_N_I), .CARD_TONE_I(CARD_TONE_I),
        .KEY_WRITE_SEL_N_I(KEY_WRITE_SEL_N_I), .KEY_READ_SEL_N_I(KEY_READ_SEL_N_I),
        .PROC_DATA_I(PROC_DATA_I), .KEY_LOAD_I(KEY_LOAD_I), .KEY_LOAD_EN_I(KEY_LOAD_EN_I),
        .SUPPLY_EN_O(SUPPLY_EN_O), .TONE_EN_O(TONE_EN_O), .CARD_CLK_O(CARD_CLK_O),
        .KEYPAD_READ_DATA_O(KEYPAD_READ_DATA_O), .KEYPAD_READ_OE_O(KEYPAD_READ_OE_O),
        .IRQ_N_O(IRQ_N_O), .TAMPER_SENSE_IN_O(TAMPER_SENSE_IN_O),
        .KEY_PROTECT_KEY_O(KEY_PROTECT_KEY_O));
    host_model host_model_i (.clock_i(CLOCK_I), .irq_n_i(IRQ_N_O), .tamper_i(TAMPER_SENSE_IN_O),
        .arm_i(arm), .reset_n_o(RESET_N_I), .supply_off_n_o(SUPPLY_OFF_N_I), .cause_o(cause));
    task automatic cyc(input int n);
        repeat (n) @(negedge CLOCK_I);
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic t_key();
        KEY_LOAD_I = KEYV;
        for (int i = 0; i < 2; i++) begin
            BACKUP_LOST_N_I = 1'b1;
            cyc(4);
            KEY_LOAD_EN_I = 1'b1;
            cyc(1);
            KEY_LOAD_EN_I = 1'b0;
            cyc(4);
            chk(KEY_PROTECT_KEY_O, KEYV);
            BACKUP_LOST_N_I = i[0];
            cyc(5);
            chk(KEY_PROTECT_KEY_O, i ? KEYV : 64'h0);
        end
    endtask
    task automatic t_routes();
        int lvl [7] = '{2, 3, 4, 5, 6, 7, 7};
        for (int i = 0; i < 7; i++) begin
            src = 7'h7F ^ (7'h01 << i);
            cyc(5);
            chk(IRQ_N_O, 7'h7F ^ (7'h01 << (lvl[i] - 1)));
            chk(TAMPER_SENSE_IN_O, i != 6);
            chk(cause, i == 6);
            src = 7'h7F;
            cyc(5);
        end
        chk(KEY_PROTECT_KEY_O, 64'h0);
    endtask
    task automatic t_tone();
        logic [3:0] tv [5] = '{4'h9, 4'hC, 4'h6, 4'hF, 4'h0};
        logic clk_prev;
        for (int i = 0; i < 5; i++) begin
            PROC_DATA_I = {1'b0, tv[i][1:0]};
            CARD_TONE_I = tv[i][2];
            KEY_WRITE_SEL_N_I = 1'b0;
            cyc(1);
            KEY_WRITE_SEL_N_I = 1'b1;
            cyc(4);
            chk(TONE_EN_O, tv[i][3]);
        end
        clk_prev = CARD_CLK_O;
        KEY_READ_SEL_N_I = 1'b0;
        cyc(1);
        chk(KEYPAD_READ_OE_O, 1'b1);
        chk(CARD_CLK_O, !clk_prev);
        KEY_READ_SEL_N_I = 1'b1;
    endtask
    task automatic t_power();
        POWER_KEY_N_I = 1'b0;
        cyc(2);
        POWER_KEY_N_I = 1'b1;
        cyc(5);
        chk(SUPPLY_EN_O, 1'b1);
        POWER_KEY_N_I = 1'b0;
        cyc(5);
        chk(IRQ_N_O[6], 1'b0);
        chk(SUPPLY_EN_O, 1'b1);
        KEY_READ_SEL_N_I = 1'b0;
        cyc(1);
        chk({KEYPAD_READ_OE_O, KEYPAD_READ_DATA_O}, 4'hD);
        KEY_READ_SEL_N_I = 1'b1;
        POWER_KEY_N_I = 1'b1;
        cyc(5);
        arm <= 1'b1;
        cyc(9);
        chk(SUPPLY_EN_O, 1'b0);
        arm <= 1'b0;
    endtask
    task automatic print_verdict();
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        #200us;
        n_errors++;
        print_verdict();
    end
    initial begin
        cyc(5);
        t_key();
        t_routes();
        t_tone();
        t_power();
        print_verdict();
    end
endmodule
